// ### rtl/odpr_defs.svh
// Offsets, field positions, reset values and timing constants of the output driver register group
`ifndef ODPR_DEFS_SVH
`define ODPR_DEFS_SVH
// ==========================================================================
// Register offsets on page 1
`define ODPR_PAGE_SEL_OFS 8'h00
`define ODPR_POP_OFS 8'h21
`define ODPR_WAIT_OFS 8'h22
`define ODPR_ROUTE_OFS 8'h23
`define ODPR_LVOL_OFS 8'h24
`define ODPR_PAGE_ONE 8'h01
// ==========================================================================
// Reset values
`define ODPR_POP_RST 8'h3e
`define ODPR_WAIT_RST 8'h00
`define ODPR_ROUTE_RST 8'h00
`define ODPR_LVOL_RST 8'h7f
// ==========================================================================
// Field positions
`define ODPR_POP_ORDER_BIT 7
`define ODPR_POP_ON_HI 6
`define ODPR_POP_ON_LO 3
`define ODPR_POP_STEP_HI 2
`define ODPR_POP_STEP_LO 1
`define ODPR_POP_CM_BIT 0
`define ODPR_WAIT_HI 6
`define ODPR_WAIT_LO 4
`define ODPR_RT_L_HI 7
`define ODPR_RT_L_LO 6
`define ODPR_RT_ANALOG_INPUT_ONE_L 5
`define ODPR_RT_ANALOG_INPUT_TWO_L 4
`define ODPR_RT_R_HI 3
`define ODPR_RT_R_LO 2
`define ODPR_RT_ANALOG_INPUT_TWO_R 1
`define ODPR_RT_DIFF 0
`define ODPR_LVOL_EN_BIT 7
// ==========================================================================
// Timing: oscillator rate in Hz, system clock in Hz
`define ODPR_OSC_HZ 8200000
`define ODPR_SYS_HZ 25000000
`endif

// ### rtl/odpr_pkg.sv
// Types shared by the output driver register group
package odpr_pkg;
   // Sequencer states
   typedef enum logic [2:0] {
      ODPR_IDLE = 3'b000,
      ODPR_PWR_ON = 3'b001,
      ODPR_RAMP = 3'b010,
      ODPR_SPK_WAIT = 3'b011,
      ODPR_UP = 3'b100,
      ODPR_DOWN = 3'b101
   } odpr_state_t;
   // Converter destination
   typedef enum logic [1:0] {
      ODPR_RT_NONE = 2'b00,
      ODPR_RT_MIX = 2'b01,
      ODPR_RT_HP = 2'b10,
      ODPR_RT_RSVD = 2'b11
   } odpr_route_t;
endpackage

// ### rtl/odpr_regs.sv
// Output driver power-up timing and routing register group with its sequencer
`timescale 1ns/1ps
`include "odpr_defs.svh"
// Function
// R1 - Order bit 0: converter powers down together with amplifiers.
// R2 - Order bit 1: converter powers down after both amplifiers are fully down.
// R3 - Four-bit power-on time code selects driver power-on duration, reset 0111.
// R4 - Software never writes codes 1100 to 1111 to power-on time.
// R5 - Two-bit ramp step code: 0, 0.98, 1.95, 3.9 ms; reset 11.
// R6 - Durations come from the oscillator, nominal 8.2 MHz, scaling with it; here sys_clk cycles fixed by OSC_HZ, not scaling.
// R7 - Common-mode source bit 0 selects supply divider; software never sets 1.
// R8 - Three-bit speaker wait code selects 0 to 30.5 ms; reset 000.
// R9 - Software writes reset values into reserved ramp-down register bits.
// R10 - Left converter route: none, left mixer, left headphone driver; 11 reserved.
// R11 - Right converter route: none, right mixer, right headphone driver; 11 reserved.
// R12 - Bit connects analog input one to the left mixer.
// R13 - Bit connects analog input two to the left mixer, reset 0.
// R14 - Bit connects analog input two to the right mixer.
// R15 - Differential bit feeds left headphone output into right driver input.
// R16 - Bit routes left analog volume to left headphone driver, reset 0.
// R17 - Seven-bit left volume gain, 0 to -78 dB, reset all ones.
// R18 - Software selects page 1 before accessing these registers.
// R19 - Weak common-mode power-down requires common-mode source bit zero.
// R20 - Durations realized by counting cycles with precomputed terminal counts.
// R21 - Reserved route code 11 leaves that converter unrouted.
module odpr_regs
   import odpr_pkg::*;
#(
   parameter int OSC_HZ = `ODPR_OSC_HZ, // Oscillator rate the codes assume
   parameter int SYS_HZ = `ODPR_SYS_HZ, // Rate of sys_clk
   parameter int SCALE_DIV = 1 // Divides every count, for short simulations
)
(
   input wire logic sys_clk, // System clock, 25 MHz
   input wire logic reset, // Synchronous reset, active high
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_addr, // Register offset within the page
   input wire logic [7:0] reg_wdata, // Write data
   output logic [7:0] reg_rdata, // Read data, valid cycle after reg_rd
   input wire logic power_up_req, // Driver power-up request level
   input wire logic power_down_req, // Software power-down request pulse
   output logic headphone_amplifiers_en, // Headphone drivers powered
   output logic speaker_amplifier_en, // Speaker driver powered
   output logic converter_en, // Converter powered
   output logic ramp_step_tick, // Pulse per gain ramp step
   output logic weak_cm_divider_sel, // Common mode from supply divider
   output logic [1:0] left_conv_route, // Left converter destination
   output logic [1:0] right_conv_route, // Right converter destination
   output logic analog_input_one_to_left, // Input one to left mixer
   output logic analog_input_two_to_left, // Input two to left mixer
   output logic analog_input_two_to_right, // Input two to right mixer
   output logic left_to_right_headphone_driver, // Differential path
   output logic left_vol_to_left_headphone_driver, // Left volume routed
   output logic [6:0] left_vol_gain // Left volume gain code
);
   // ==========================================================================
   // Timing: a 64-bit product keeps the cycle conversion exact
   localparam longint unsigned NUM = longint'(SYS_HZ);
   localparam longint unsigned DEN = longint'(OSC_HZ) * longint'(SCALE_DIV);
   // Oscillator cycles per code at 8.2 MHz (times in ns scaled by 0.0082)
   // Counts are 28 bits: the 6.1 s code is about 152.5 million cycles at 25 MHz,
   // which would wrap in 27 bits and cut the longest power-on wait short
   function automatic logic [27:0] cyc(input longint unsigned osc);
      longint unsigned v;
      v = (osc * NUM) / DEN;
      cyc = v[27:0];
   endfunction
   // Power-on time codes; 0010 is shorter than 0001 and 1001 runs 4.22 s, both kept
   function automatic logic [27:0] on_cnt(input logic [3:0] c);
      case (c)
         4'h0: on_cnt = 28'h0;
         4'h1: on_cnt = cyc(64'd125); // 15.3 us
         4'h2: on_cnt = cyc(64'd13); // 1.53 us
         4'h3: on_cnt = cyc(64'd12546); // 1.53 ms
         4'h4: on_cnt = cyc(64'd125460); // 15.3 ms
         4'h5: on_cnt = cyc(64'd624840); // 76.2 ms
         4'h6: on_cnt = cyc(64'd1254600); // 153 ms
         4'h7: on_cnt = cyc(64'd2492800); // 304 ms
         4'h8: on_cnt = cyc(64'd5002000); // 610 ms
         4'h9: on_cnt = cyc(64'd34604000); // 4.22 s
         4'ha: on_cnt = cyc(64'd24928000); // 3.04 s
         4'hb: on_cnt = cyc(64'd50020000); // 6.1 s
         default: on_cnt = 28'h0; // Reserved codes: no wait
      endcase
   endfunction
   // Ramp step codes; code 00 steps with no wait at all
   function automatic logic [27:0] step_cnt(input logic [1:0] c);
      case (c)
         2'h1: step_cnt = cyc(64'd8036); // 0.98 ms
         2'h2: step_cnt = cyc(64'd15990); // 1.95 ms
         2'h3: step_cnt = cyc(64'd31980); // 3.9 ms
         default: step_cnt = 28'h0;
      endcase
   endfunction
   // Speaker power-up wait codes
   function automatic logic [27:0] wait_cnt(input logic [2:0] c);
      case (c)
         3'h1: wait_cnt = cyc(64'd24928); // 3.04 ms
         3'h2: wait_cnt = cyc(64'd62484); // 7.62 ms
         3'h3: wait_cnt = cyc(64'd100040); // 12.2 ms
         3'h4: wait_cnt = cyc(64'd125460); // 15.3 ms
         3'h5: wait_cnt = cyc(64'd162360); // 19.8 ms
         3'h6: wait_cnt = cyc(64'd200080); // 24.4 ms
         3'h7: wait_cnt = cyc(64'd250100); // 30.5 ms
         default: wait_cnt = 28'h0;
      endcase
   endfunction
   // Step count is fixed; the field sets only how long each step lasts
   localparam logic [3:0] RAMP_STEPS = 4'h8; // Gain steps per ramp
   // ==========================================================================
   // Registers
   logic [7:0] page_q;
   logic [7:0] pop_q;
   logic [7:0] wait_q;
   logic [7:0] route_q;
   logic [7:0] lvol_q;
   logic [7:0] rdata_q;
   // Page register answers on every page, the group only on page one
   wire on_page1 = (page_q == `ODPR_PAGE_ONE); // R18
   wire wr_page = reg_wr && reg_addr == `ODPR_PAGE_SEL_OFS;
   wire wr_pop = reg_wr && on_page1 && reg_addr == `ODPR_POP_OFS;
   wire wr_wait = reg_wr && on_page1 && reg_addr == `ODPR_WAIT_OFS;
   wire wr_route = reg_wr && on_page1 && reg_addr == `ODPR_ROUTE_OFS;
   wire wr_lvol = reg_wr && on_page1 && reg_addr == `ODPR_LVOL_OFS;
   // Writes stored as given; reserved bits are software's to keep
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         page_q <= 8'h00;
         pop_q <= `ODPR_POP_RST; // R3 R5
         wait_q <= `ODPR_WAIT_RST; // R8 R9
         route_q <= `ODPR_ROUTE_RST; // R13
         lvol_q <= `ODPR_LVOL_RST; // R16 R17
      end
      else
      begin
         page_q <= wr_page ? reg_wdata : page_q;
         pop_q <= wr_pop ? reg_wdata : pop_q; // R4 R7
         wait_q <= wr_wait ? reg_wdata : wait_q; // R9
         route_q <= wr_route ? reg_wdata : route_q;
         lvol_q <= wr_lvol ? reg_wdata : lvol_q;
      end
   end
   // Read mux; other offsets and other pages read zero
   logic [7:0] rd_mux;
   assign rd_mux = (reg_addr == `ODPR_PAGE_SEL_OFS) ? page_q :
      !on_page1 ? 8'h00 :
      (reg_addr == `ODPR_POP_OFS) ? pop_q :
      (reg_addr == `ODPR_WAIT_OFS) ? wait_q :
      (reg_addr == `ODPR_ROUTE_OFS) ? route_q :
      (reg_addr == `ODPR_LVOL_OFS) ? lvol_q : 8'h00;
   // Read data latched on the strobe and held until the next read
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         rdata_q <= 8'h00;
      else if (reg_rd)
         rdata_q <= rd_mux;
   end
   assign reg_rdata = rdata_q;
   // ==========================================================================
   // Routing outputs, registered; reserved code 11 maps to unrouted
   wire [1:0] l_fld = route_q[`ODPR_RT_L_HI:`ODPR_RT_L_LO];
   wire [1:0] r_fld = route_q[`ODPR_RT_R_HI:`ODPR_RT_R_LO];
   wire [1:0] l_rt = (l_fld == ODPR_RT_RSVD) ? ODPR_RT_NONE : l_fld; // R10 R21
   wire [1:0] r_rt = (r_fld == ODPR_RT_RSVD) ? ODPR_RT_NONE : r_fld; // R11 R21
   // Routing flops; every output comes straight from one of them
   logic [1:0] l_rt_q;
   logic [1:0] r_rt_q;
   logic [4:0] sw_q;
   logic [6:0] gain_q;
   logic cm_q;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         l_rt_q <= ODPR_RT_NONE;
         r_rt_q <= ODPR_RT_NONE;
         sw_q <= 5'h00;
         gain_q <= 7'h7f;
         cm_q <= 1'b1;
      end
      else
      begin
         l_rt_q <= l_rt;
         r_rt_q <= r_rt;
         sw_q <= {route_q[`ODPR_RT_ANALOG_INPUT_ONE_L], // R12
            route_q[`ODPR_RT_ANALOG_INPUT_TWO_L], // R13
            route_q[`ODPR_RT_ANALOG_INPUT_TWO_R], // R14
            route_q[`ODPR_RT_DIFF], // R15
            lvol_q[`ODPR_LVOL_EN_BIT]}; // R16
         gain_q <= lvol_q[6:0]; // R17
         cm_q <= !pop_q[`ODPR_POP_CM_BIT]; // R7 R19
      end
   end
   // Routing and volume outputs
   assign left_conv_route = l_rt_q;
   assign right_conv_route = r_rt_q;
   assign analog_input_one_to_left = sw_q[4];
   assign analog_input_two_to_left = sw_q[3];
   assign analog_input_two_to_right = sw_q[2];
   assign left_to_right_headphone_driver = sw_q[1];
   assign left_vol_to_left_headphone_driver = sw_q[0];
   assign left_vol_gain = gain_q;
   assign weak_cm_divider_sel = cm_q;
   // ==========================================================================
   // Power sequencer
   // A start pulse reloads the timer, so a stale count never leaks into a phase
   odpr_timer_if tif();
   odpr_timer u_timer (
      .sys_clk(sys_clk),
      .reset(reset),
      .tif(tif)
   );
   // Sequencer state, step count and registered enables
   odpr_state_t st_q;
   odpr_state_t st_d;
   logic [3:0] steps_q;
   logic hp_q;
   logic spk_q;
   logic conv_q;
   logic tick_q;
   logic start_d;
   logic [27:0] cnt_d;
   // Order bit read live, so it takes effect on the next power-down
   wire order_late = pop_q[`ODPR_POP_ORDER_BIT];
   // Next state and timer load; each phase waits its precomputed count
   always_comb
   begin
      st_d = st_q;
      start_d = 1'b0;
      cnt_d = 28'h0;
      case (st_q)
         ODPR_IDLE:
            if (power_up_req)
            begin
               st_d = ODPR_PWR_ON;
               start_d = 1'b1;
               cnt_d = on_cnt(pop_q[`ODPR_POP_ON_HI:`ODPR_POP_ON_LO]); // R3 R20
            end
         ODPR_PWR_ON, ODPR_RAMP:
            if (power_down_req)
               st_d = ODPR_DOWN;
            else if (tif.done && st_q == ODPR_RAMP && steps_q == RAMP_STEPS)
            begin
               st_d = ODPR_SPK_WAIT;
               start_d = 1'b1;
               cnt_d = wait_cnt(wait_q[`ODPR_WAIT_HI:`ODPR_WAIT_LO]); // R8 R6
            end
            else if (tif.done)
            begin
               st_d = ODPR_RAMP;
               start_d = 1'b1;
               cnt_d = step_cnt(pop_q[`ODPR_POP_STEP_HI:`ODPR_POP_STEP_LO]); // R5 R6
            end
         ODPR_SPK_WAIT:
            if (power_down_req)
               st_d = ODPR_DOWN;
            else if (tif.done)
               st_d = ODPR_UP;
         ODPR_UP:
            if (power_down_req)
               st_d = ODPR_DOWN;
         ODPR_DOWN:
            st_d = ODPR_IDLE;
         default:
            st_d = ODPR_IDLE;
      endcase
   end
   // State, amplifier and converter enables
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         st_q <= ODPR_IDLE;
         steps_q <= 4'h0;
         hp_q <= 1'b0;
         spk_q <= 1'b0;
         conv_q <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         tick_q <= st_q == ODPR_RAMP && tif.done;
         steps_q <= (st_d == ODPR_RAMP && start_d) ? steps_q + 4'h1 :
            (st_d == ODPR_IDLE) ? 4'h0 : steps_q;
         hp_q <= st_d != ODPR_IDLE && st_d != ODPR_DOWN;
         spk_q <= st_d == ODPR_UP;
         // Amplifiers are off as DOWN is entered, so late order drops one cycle after
         conv_q <= (st_d == ODPR_IDLE && st_q == ODPR_DOWN) ? 1'b0 : // R2
            (st_d == ODPR_DOWN) ? order_late : // R1 R2
            (st_d == ODPR_IDLE) ? 1'b0 : 1'b1;
      end
   end
   // Timer load and enable outputs
   assign tif.start = start_d;
   assign tif.count = cnt_d;
   assign headphone_amplifiers_en = hp_q;
   assign speaker_amplifier_en = spk_q;
   assign converter_en = conv_q;
   assign ramp_step_tick = tick_q;
endmodule // odpr_regs

// ### rtl/odpr_timer.sv
// Duration timer counting sys_clk cycles
`timescale 1ns/1ps
module odpr_timer
   import odpr_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic reset, // Synchronous reset
   odpr_timer_if.tmr tif // Start, count and done
);
   logic [27:0] left_q;
   logic busy_q;
   logic done_q;
   // ==========================================================================
   // Countdown; a start while busy restarts the count
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         left_q <= 28'h0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (tif.start)
      begin
         left_q <= tif.count;
         busy_q <= 1'b1;
         done_q <= 1'b0;
      end
      else if (busy_q && left_q == 28'h0)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b1;
      end
      else
      begin
         left_q <= busy_q ? left_q - 28'h1 : left_q;
         done_q <= 1'b0;
      end
   end
   assign tif.done = done_q;
endmodule // odpr_timer

// ### rtl/odpr_timer_if.sv
// Interface between the sequencer and its duration timer
`timescale 1ns/1ps
interface odpr_timer_if;
   logic start;
   logic [27:0] count;
   logic done;
   modport seq (output start, output count, input done);
   modport tmr (input start, input count, output done);
endinterface

// ### sim/odpr_monitor.sv
// Checker of the output driver register group, bound to its top module
`timescale 1ns/1ps
module odpr_monitor (
   input wire logic sys_clk, // Clock
   input wire logic reset, // Sync reset
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_addr, // Offset
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic power_down_req, // Down pulse
   input wire logic headphone_amplifiers_en, // Headphone on
   input wire logic speaker_amplifier_en, // Speaker on
   input wire logic converter_en, // Converter on
   input wire logic ramp_step_tick, // Ramp tick
   input wire logic weak_cm_divider_sel, // Divider select
   input wire logic [1:0] left_conv_route, // Left dest
   input wire logic [1:0] right_conv_route, // Right dest
   input wire logic analog_input_one_to_left, // In one left
   input wire logic analog_input_two_to_left, // In two left
   input wire logic analog_input_two_to_right, // In two right
   input wire logic left_to_right_headphone_driver, // Differential
   input wire logic left_vol_to_left_headphone_driver, // Volume route
   input wire logic [6:0] left_vol_gain // Gain code
);
   // ======================================================================
   // Helpers: page and order bit as software set them, write data delayed
   logic [7:0] page_q;
   logic order_q;
   logic [7:0] wd1_q;
   logic [7:0] wd2_q;
   wire page_wr = reg_wr && page_q == 8'h01;
   wire [1:0] left_exp = wd2_q[7:6] == 2'b11 ? 2'b00 : wd2_q[7:6];
   wire [1:0] right_exp = wd2_q[3:2] == 2'b11 ? 2'b00 : wd2_q[3:2];
   // Page writes land on any page, order bit only on page one
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         page_q <= 8'h00;
         order_q <= 1'b0;
      end
      else
      begin
         if (reg_wr && reg_addr == 8'h00) page_q <= reg_wdata;
         if (page_wr && reg_addr == 8'h21) order_q <= reg_wdata[7];
      end
   end
   // Outputs follow a write two edges later
   always_ff @(posedge sys_clk)
   begin
      wd1_q <= reg_wdata;
      wd2_q <= wd1_q;
   end
   // ======================================================================
   // Assertions
   default clocking mon_cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   reset_vals_a: assert property (disable iff (1'b0) reset |=>
      left_vol_gain == 7'h7f && left_conv_route == 2'b00 && !converter_en
      && !headphone_amplifiers_en && weak_cm_divider_sel && reg_rdata == 8'h00)
      else $error("outputs not at reset values");
   left_route_a: assert property (page_wr && reg_addr == 8'h23 |-> ##2
      left_conv_route == left_exp) else $error("left route wrong");
   right_route_a: assert property (page_wr && reg_addr == 8'h23 |-> ##2
      right_conv_route == right_exp) else $error("right route wrong");
   mixer_bits_a: assert property (page_wr && reg_addr == 8'h23 |-> ##2
      {analog_input_one_to_left, analog_input_two_to_left, analog_input_two_to_right,
      left_to_right_headphone_driver} == {wd2_q[5:4], wd2_q[1:0]})
      else $error("mixer bits wrong");
   left_vol_a: assert property (page_wr && reg_addr == 8'h24 |-> ##2
      {left_vol_to_left_headphone_driver, left_vol_gain} == wd2_q)
      else $error("left volume wrong");
   cm_source_a: assert property (page_wr && reg_addr == 8'h21 |-> ##2
      weak_cm_divider_sel == !wd2_q[0]) else $error("divider select wrong");
   amps_drop_a: assert property (power_down_req && headphone_amplifiers_en |=>
      !headphone_amplifiers_en && !speaker_amplifier_en) else $error("amps stay on");
   conv_with_a: assert property (power_down_req && headphone_amplifiers_en && !order_q
      |=> !converter_en) else $error("converter late");
   conv_after_a: assert property (power_down_req && headphone_amplifiers_en
      && converter_en && order_q |=> converter_en ##1 !converter_en)
      else $error("converter order wrong");
   hp_first_a: assert property ($rose(speaker_amplifier_en) |-> headphone_amplifiers_en)
      else $error("speaker before headphone");
   page_refuse_a: assert property (reg_rd && page_q != 8'h01
      && reg_addr inside {[8'h21:8'h24]} |-> ##[1:2] reg_rdata == 8'h00)
      else $error("read off page not refused");
   rdata_hold_a: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
      else $error("read data moved");
   // Main scenarios reached
   cover property ($rose(speaker_amplifier_en));
   cover property (ramp_step_tick);
   cover property (page_wr && reg_addr == 8'h23 && reg_wdata[7:6] == 2'b11);
endmodule // odpr_monitor
bind odpr_regs odpr_monitor odpr_monitor_inst (.sys_clk, .reset, .reg_wr, .reg_rd,
   .reg_addr, .reg_wdata, .reg_rdata, .power_down_req, .headphone_amplifiers_en,
   .speaker_amplifier_en, .converter_en, .ramp_step_tick, .weak_cm_divider_sel,
   .left_conv_route, .right_conv_route, .analog_input_one_to_left, .analog_input_two_to_left,
   .analog_input_two_to_right, .left_to_right_headphone_driver,
   .left_vol_to_left_headphone_driver, .left_vol_gain);

// ### sim/odpr_regs_tb_top.sv
// Self-checking testbench of the output driver register group
`timescale 1ns/1ps
module odpr_regs_tb_top import odpr_pkg::*;;
   // ======================================================================
   // Signals; counts shortened by SD to keep the run brief
   localparam int SD = 10000;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr = 1'b0, reg_rd = 1'b0, power_up_req = 1'b0, power_down_req = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, pg = 8'h00;
   logic headphone_amplifiers_en, speaker_amplifier_en, converter_en, ramp_step_tick;
   logic weak_cm_divider_sel, analog_input_one_to_left, analog_input_two_to_left;
   logic analog_input_two_to_right, left_to_right_headphone_driver;
   logic left_vol_to_left_headphone_driver;
   logic [1:0] left_conv_route, right_conv_route;
   logic [6:0] left_vol_gain;
   logic [7:0] mdl [4];
   logic [31:0] lfsr_q = 32'h57ef06fd;
   int failures = 0, n_tests = 0;
   // Durations in units of 10 ns at the nominal oscillator rate
   int on_t [16] = '{0, 1530, 153, 153000, 1530000, 7620000, 15300000, 30400000,
      61000000, 422000000, 304000000, 610000000, 0, 0, 0, 0};
   int step_t [4] = '{0, 98000, 195000, 390000};
   int wait_t [8] = '{0, 304000, 762000, 1220000, 1530000, 1980000, 2440000, 3050000};
   logic [7:0] corner [5] = '{8'h5e, 8'hcc, 8'h92, 8'h52, 8'h44};
   always #20 sys_clk = ~sys_clk;
   odpr_regs #(.SCALE_DIV(SD)) odpr_regs_inst (.sys_clk, .reset, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .power_up_req, .power_down_req,
      .headphone_amplifiers_en, .speaker_amplifier_en, .converter_en, .ramp_step_tick,
      .weak_cm_divider_sel, .left_conv_route, .right_conv_route, .analog_input_one_to_left,
      .analog_input_two_to_left, .analog_input_two_to_right, .left_to_right_headphone_driver,
      .left_vol_to_left_headphone_driver, .left_vol_gain);
   // ======================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
      return lfsr_q;
   endfunction
   // Software side keeps reserved codes and bits clear
   function automatic logic [7:0] legal(input int i, input logic [7:0] d);
      case (i)
         0: return {d[7], 1'b0, d[5:1], 1'b0};
         1: return {1'b0, d[6:4], 4'h0};
         2: return {d[7], d[6] & ~d[7], d[5:3], d[2] & ~d[3], d[1:0]};
         default: return d;
      endcase
   endfunction
   function automatic logic [1:0] rt(input logic [1:0] c);
      return c == 2'b11 ? 2'b00 : c;
   endfunction
   function automatic int exp_cyc(input logic [7:0] pop, input logic [7:0] wt);
      return (on_t[pop[6:3]] + 8 * step_t[pop[2:1]] + wait_t[wt[6:4]]) / (4 * SD);
   endfunction
   task automatic tick(input int n = 1);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick();
      reg_wr = 1'b0;
      if (a == 8'h00) pg = d;
      if (pg == 8'h01 && a >= 8'h21 && a <= 8'h24) mdl[a - 8'h21] = d;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_rd = 1'b1;
      reg_addr = a;
      tick();
      reg_rd = 1'b0;
      tick();
      check(reg_rdata, exp);
   endtask
   task automatic chk_out();
      tick(2);
      check({left_conv_route, right_conv_route}, {rt(mdl[2][7:6]), rt(mdl[2][3:2])});
      check({analog_input_one_to_left, analog_input_two_to_left, analog_input_two_to_right,
         left_to_right_headphone_driver}, {mdl[2][5:4], mdl[2][1:0]});
      check({left_vol_to_left_headphone_driver, left_vol_gain}, mdl[3]);
      check(weak_cm_divider_sel, !mdl[0][0]);
   endtask
   // Full power-up, then a software power-down
   task automatic pwr(input logic [7:0] pop, input logic [7:0] wt);
      int cyc, ticks, exp;
      logic conv;
      wr(8'h21, pop);
      wr(8'h22, wt);
      exp = exp_cyc(pop, wt);
      cyc = 0;
      ticks = 0;
      power_up_req = 1'b1;
      while (!speaker_amplifier_en && cyc < 20000)
      begin
         tick();
         cyc++;
         ticks += int'(ramp_step_tick);
         if (cyc == 2) check(headphone_amplifiers_en, 1'b1);
      end
      if (cyc >= 20000)
      begin
         failures++;
         end_sim();
      end
      check(ticks, 8);
      // Ten timed phases add two hand-over edges each, one more to start
      check(cyc >= exp + 8 && cyc <= exp + 26 + exp / 20, 1'b1);
      tick(3);
      conv = converter_en;
      power_up_req = 1'b0;
      power_down_req = 1'b1;
      tick();
      power_down_req = 1'b0;
      check({headphone_amplifiers_en, speaker_amplifier_en, converter_en}, {2'b00, conv & pop[7]});
      tick();
      check(converter_en, 1'b0);
      tick(3);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ======================================================================
   // Main sequence
   initial
   begin
      int i;
      mdl = '{8'h3e, 8'h00, 8'h00, 8'h7f};
      tick(5);
      reset = 1'b0;
      rd(8'h21, 8'h00);
      chk_out();
      wr(8'h24, 8'h12);
      wr(8'h00, 8'h01);
      rd(8'h00, 8'h01);
      for (i = 0; i < 4; i++) rd(8'(33 + i), mdl[i]);
      rd(8'h25, 8'h00);
      $display("reset and paging test done");
      for (int n = 0; n < 24; n++)
      begin
         i = int'(rnd() % 4);
         wr(8'(33 + i), legal(i, 8'(rnd())));
         chk_out();
         rd(8'(33 + i), mdl[i]);
      end
      for (int c = 0; c < 4; c++)
      begin
         wr(8'h23, 8'(c * 68 + c));
         chk_out();
      end
      wr(8'h00, 8'h02);
      wr(8'h24, 8'h55);
      rd(8'h24, 8'h00);
      wr(8'h00, 8'h01);
      rd(8'h24, mdl[3]);
      $display("register and routing test done");
      for (int n = 0; n < 7; n++)
         pwr(n < 5 ? corner[n] : legal(0, 8'(rnd())), legal(1, 8'(rnd())));
      $display("power sequence test done");
      end_sim();
   end
endmodule // odpr_regs_tb_top
